// *** rtl/rsc_pkg.sv ***
/*
 * Constants shared by the real-time clock sync / interrupt / offset
 * calibration block: register offsets, field positions, reset values,
 * keys and prescaler constants.
 * Assumes a 32-bit classic Wishbone register bus; offsets are byte addresses.
 */
package rsc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_EN = 8'h04;
    localparam logic [7:0] OFS_FLAGS = 8'h08;
    localparam logic [7:0] OFS_VECTOR = 8'h0C;
    localparam logic [7:0] OFS_PS_CTRL = 8'h10;
    localparam logic [7:0] OFS_OCAL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // field positions
    localparam int CTRL_HOLD_BIT = 0;
    localparam int OCAL_SIGN_BIT = 15;
    localparam int PS_FAST_LSB = 0;
    localparam int PS_SLOW_LSB = 3;
    localparam int PS_TEV_LSB = 6;
    localparam int PS_CALF_LSB = 8;
    // flag bit index, highest priority first
    localparam int FLG_OSC = 0;
    localparam int FLG_RS = 1;
    localparam int FLG_TEV = 2;
    localparam int FLG_ALARM = 3;
    localparam int FLG_FAST = 4;
    localparam int FLG_SLOW = 5;
    localparam int NUM_FLAGS = 6;
    // reset values
    localparam logic RST_HOLD = 1'b1;
    localparam logic [5:0] RST_IRQ_EN = 6'h00;
    localparam logic [9:0] RST_PS_CTRL = 10'h000;
    localparam logic [7:0] RST_OCAL_MAG = 8'h00;
    // key protection
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam logic [7:0] KEY_READBACK = 8'h96;
    // keep-out window, in crystal ticks: 64 before and 64 after the update
    localparam logic [7:0] KEEPOUT_PRE_START = 8'hC0;
    localparam logic [7:0] KEEPOUT_POST_END = 8'h40;
    localparam logic [6:0] SLOW_LAST = 7'h7F;
    // calibration
    localparam logic [7:0] CAL_MAX_PPM = 8'hF0;
    localparam logic [5:0] CAL_PERIOD_LAST = 6'h3B;
    localparam logic [4:0] QUARTER_LAST = 5'h1F;
    localparam logic [1:0] CAL_SKIP_TICKS = 2'h2;
    // codes
    localparam logic [1:0] CALF_OFF = 2'h0;
    localparam logic [1:0] CALF_512 = 2'h1;
    localparam logic [1:0] CALF_256 = 2'h2;
    localparam logic [1:0] TEV_MINUTE = 2'h0;
    localparam logic [1:0] TEV_HOUR = 2'h1;
    localparam logic [1:0] TEV_MIDNIGHT = 2'h2;
endpackage

// *** rtl/rsc_rtc_core.sv ***
/*
 * Read synchronisation, prioritised interrupt vector and crystal offset
 * calibration of a real-time clock, with a classic Wishbone slave.
 * Assumes the crystal clock arrives as a level on i_xtal_clk, much slower
 * than i_clock, and that calendar/alarm logic elsewhere supplies the
 * event pulses and consumes o_second_tick.
 */
// Functional notes
// R1 - read-stable low in 128-tick window around update
// R2 - read-stable rising edge sets its flag
// R3 - vector read or software write clears flag
// R4 - software discards reads while read-stable low
// R5 - counting write stops clock, zeroes both prescalers
// R6 - six flags form one prioritised vector
// R7 - codes 2,4,6,8,A,C; 0 none
// R8 - vector write clears all, read clears highest
// R9 - alarm match sets alarm flag, enable gates
// R10 - interval flag on minute/hour/midnight/noon, gated
// R11 - fast flag taps 16384 Hz to 128 Hz
// R12 - slow flag taps 64 Hz to 0.5 Hz
// R13 - changing tap select may set prescaler flag
// R14 - oscillator failure sets fault flag
// R15 - eight-bit magnitude plus sign, one ppm steps
// R16 - correction capped at 240 per 60 s
// R17 - calibration writes need unlocked key
// R18 - calibration reads return written value
// R19 - calibration write zeroes temp comp; idle when zero/held
// R20 - add/remove one Q0 pulse per quarter second
// R21 - calibration pin off, 512, 256 or 1 Hz
// R22 - outputs corrected except fast tap zero
// R23 - 256 fast ticks clock slow; 128 make second
// R24 - hold stops both prescalers
// R25 - key A5 unlocks, wrong key locks, reads 96
// R26 - crystal-side signals pass two-flop synchronisers
// R27 - interval select two bits, minute hour midnight noon
// R28 - tap select three bits, zero fastest
`timescale 1ns/1ns
module rsc_rtc_core (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // crystal and the rest of the clock module
    input wire logic i_xtal_clk,
    input wire logic i_osc_fault,
    input wire logic i_count_write,
    input wire logic i_alarm_match,
    input wire logic i_minute_change,
    input wire logic i_hour_change,
    input wire logic i_midnight,
    input wire logic i_noon,
    output logic o_second_tick,
    output logic o_temp_comp_clear,
    output logic o_counter_hold,
    output logic o_unlocked,
    // interrupt request and calibration clock pin
    output logic o_irq,
    output logic o_cal_clock_pin,
    output logic o_cal_clock_oe
);
    // priority encode: code for lowest set index, 0 when none
    function automatic logic [3:0] vec_code(input logic [5:0] pend);
        logic [3:0] code;
        code = 4'h0;
        for (int i = rsc_pkg::NUM_FLAGS - 1; i >= 0; i--) begin
            if (pend[i]) begin
                code = 4'(2 * (i + 1));
            end
        end
        return code;
    endfunction

    function automatic logic [5:0] low_mask(input logic [5:0] pend);
        return pend & (~pend + 6'h01);
    endfunction

    logic xt_meta_q, xt_sync_q, xt_prev_q;
    logic of_meta_q, of_sync_q, of_prev_q;
    logic rs_meta_q, rs_q, rs_prev_q;
    logic [7:0] fast_q;
    logic [6:0] slow_q;
    logic raw_q0_q, sec_par_q;
    logic [5:0] sec_cnt_q;
    logic [7:0] cal_left_q;
    logic [1:0] skip_q;
    logic hold_q, unlocked_q;
    logic [5:0] irq_en_q, flags_q;
    logic [9:0] ps_ctrl_q;
    logic [7:0] ocal_mag_q;
    logic ocal_sign_q;
    logic fast_tap_prev_q, slow_tap_prev_q;
    logic [31:0] rdat_q;
    logic ack_q, sec_tick_q, tc_clear_q, cal_pin_q;

    logic xt_tick, fast_carry, qtr_tick, cal_fire, advance;
    logic [8:0] fast_sum;
    logic read_stable_c, fast_tap, slow_tap, tev_event;
    logic bus_go, bus_wr, bus_rd, key_ok;
    logic ctrl_wr, en_wr, flg_wr, vec_wr, vec_rd, ps_wr, ocal_wr;
    logic [5:0] pending, hi_mask, flag_set, flag_clr;
    logic [3:0] vec;
    logic [31:0] rdat_d;

    logic [2:0] fast_sel, slow_sel;
    logic [1:0] tev_sel, calf_sel;
    assign fast_sel = ps_ctrl_q[rsc_pkg::PS_FAST_LSB +: 3];
    assign slow_sel = ps_ctrl_q[rsc_pkg::PS_SLOW_LSB +: 3];
    assign tev_sel = ps_ctrl_q[rsc_pkg::PS_TEV_LSB +: 2];
    assign calf_sel = ps_ctrl_q[rsc_pkg::PS_CALF_LSB +: 2];

    // synchronisers; first stage feeds only the second
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            xt_meta_q <= 1'b0;
            xt_sync_q <= 1'b0;
            xt_prev_q <= 1'b0;
            of_meta_q <= 1'b0;
            of_sync_q <= 1'b0;
            of_prev_q <= 1'b0;
        end else begin
            xt_meta_q <= i_xtal_clk; // [R26]
            xt_sync_q <= xt_meta_q;
            xt_prev_q <= xt_sync_q;
            of_meta_q <= i_osc_fault; // [R26]
            of_sync_q <= of_meta_q;
            of_prev_q <= of_sync_q;
        end
    end
    assign xt_tick = xt_sync_q & ~xt_prev_q;

    // prescaler chain with offset correction
    assign fast_sum = {1'b0, fast_q} + (cal_fire & ocal_sign_q ? 9'h003 : 9'h001); // [R20]
    assign advance = xt_tick & ~hold_q & (skip_q == 2'h0); // [R24]
    // carry taken from the count itself, not the sum, to keep the sum out of a loop
    assign fast_carry = advance & (&fast_q); // [R23]
    assign qtr_tick = fast_carry & (slow_q[4:0] == rsc_pkg::QUARTER_LAST);
    assign cal_fire = qtr_tick & (cal_left_q != 8'h00); // [R19]

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            fast_q <= 8'h00;
            slow_q <= 7'h00;
            raw_q0_q <= 1'b0;
            skip_q <= 2'h0;
        end else if (i_count_write) begin
            fast_q <= 8'h00; // [R5]
            slow_q <= 7'h00;
            raw_q0_q <= 1'b0;
            skip_q <= 2'h0;
        end else if (xt_tick && !hold_q) begin
            raw_q0_q <= ~raw_q0_q; // [R22]
            if (skip_q != 2'h0) begin
                skip_q <= skip_q - 2'h1;
            end else begin
                fast_q <= fast_sum[7:0];
                if (fast_sum[8]) begin
                    slow_q <= slow_q + 7'h01; // [R23]
                end
                if (cal_fire && !ocal_sign_q) begin
                    skip_q <= rsc_pkg::CAL_SKIP_TICKS; // [R20]
                end
            end
        end
    end

    // seconds, calibration period and remaining correction count
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            sec_cnt_q <= 6'h00;
            sec_par_q <= 1'b0;
            cal_left_q <= 8'h00;
            sec_tick_q <= 1'b0;
        end else begin
            sec_tick_q <= fast_carry && slow_q == rsc_pkg::SLOW_LAST; // [R23]
            if (fast_carry && slow_q == rsc_pkg::SLOW_LAST) begin
                sec_par_q <= ~sec_par_q;
                if (sec_cnt_q == rsc_pkg::CAL_PERIOD_LAST) begin
                    sec_cnt_q <= 6'h00;
                end else begin
                    sec_cnt_q <= sec_cnt_q + 6'h01;
                end
            end
            // a quarter tick also lands on every second wrap; on the period wrap the reload wins and it does not count
            if (fast_carry && slow_q == rsc_pkg::SLOW_LAST &&
                    sec_cnt_q == rsc_pkg::CAL_PERIOD_LAST) begin
                // cap at the legal range
                cal_left_q <= (ocal_mag_q > rsc_pkg::CAL_MAX_PPM) ?
                    rsc_pkg::CAL_MAX_PPM : ocal_mag_q; // [R16]
            end else if (cal_fire) begin
                cal_left_q <= cal_left_q - 8'h01; // [R20]
            end
        end
    end
    assign o_second_tick = sec_tick_q;

    // keep-out window straddles the slow wrap
    assign read_stable_c = !((slow_q == rsc_pkg::SLOW_LAST &&
                              fast_q >= rsc_pkg::KEEPOUT_PRE_START) ||
                             (slow_q == 7'h00 && fast_q < rsc_pkg::KEEPOUT_POST_END)); // [R1]

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rs_meta_q <= 1'b1;
            rs_q <= 1'b1;
            rs_prev_q <= 1'b1;
            fast_tap_prev_q <= 1'b0;
            slow_tap_prev_q <= 1'b0;
        end else begin
            rs_meta_q <= read_stable_c; // [R26]
            rs_q <= rs_meta_q;
            rs_prev_q <= rs_q;
            fast_tap_prev_q <= fast_tap;
            slow_tap_prev_q <= slow_tap;
        end
    end

    // tap zero is the uncorrected Q0; a select change can fake an edge
    assign fast_tap = (fast_sel == 3'h0) ? raw_q0_q : fast_q[fast_sel]; // [R11] [R22] [R28]
    assign slow_tap = (slow_sel == 3'h7) ? sec_par_q : slow_q[slow_sel]; // [R12] [R28]

    always_comb begin
        case (tev_sel) // [R27]
            rsc_pkg::TEV_MINUTE: tev_event = i_minute_change;
            rsc_pkg::TEV_HOUR: tev_event = i_hour_change;
            rsc_pkg::TEV_MIDNIGHT: tev_event = i_midnight;
            default: tev_event = i_noon;
        endcase
    end

    assign flag_set = {slow_tap_prev_q & ~slow_tap, // [R12] [R13]
                       fast_tap_prev_q & ~fast_tap, // [R11] [R13]
                       i_alarm_match, // [R9]
                       tev_event, // [R10]
                       rs_q & ~rs_prev_q, // [R2]
                       of_sync_q & ~of_prev_q}; // [R14]

    // wishbone decode; effects happen on the edge that raises ack
    assign bus_go = i_wb_cyc & i_wb_stb & ~ack_q;
    assign bus_wr = bus_go & i_wb_we;
    assign bus_rd = bus_go & ~i_wb_we;
    assign ctrl_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_CTRL;
    assign en_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_IRQ_EN && i_wb_sel[0];
    assign flg_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_FLAGS && i_wb_sel[0];
    assign vec_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_VECTOR;
    assign vec_rd = bus_rd && i_wb_adr == rsc_pkg::OFS_VECTOR;
    assign ps_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_PS_CTRL;
    assign ocal_wr = bus_wr && i_wb_adr == rsc_pkg::OFS_OCAL && unlocked_q; // [R17]
    assign key_ok = i_wb_dat[15:8] == rsc_pkg::UNLOCK_KEY;

    assign pending = flags_q & irq_en_q; // [R6]
    assign hi_mask = low_mask(pending);
    assign vec = vec_code(pending); // [R7]
    // servicing clears only the winner; flags_q written 1 clears any
    assign flag_clr = vec_wr ? {rsc_pkg::NUM_FLAGS{1'b1}} : // [R8]
                      (vec_rd ? hi_mask : 6'h00) | // [R3] [R8]
                      (flg_wr ? i_wb_dat[5:0] : 6'h00);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flags_q <= 6'h00;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set; // set wins [R8]
        end
    end
    assign o_irq = |pending; // [R8]

    // control and key
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            hold_q <= rsc_pkg::RST_HOLD;
            unlocked_q <= 1'b0;
        end else if (ctrl_wr) begin
            if (i_wb_sel[1]) begin
                unlocked_q <= key_ok; // [R25]
            end
            if (i_wb_sel[0] && (unlocked_q || (i_wb_sel[1] && key_ok))) begin
                hold_q <= i_wb_dat[rsc_pkg::CTRL_HOLD_BIT]; // [R24]
            end
        end
    end
    assign o_counter_hold = hold_q;
    assign o_unlocked = unlocked_q;

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            irq_en_q <= rsc_pkg::RST_IRQ_EN;
            ps_ctrl_q <= rsc_pkg::RST_PS_CTRL;
        end else begin
            if (en_wr) begin
                irq_en_q <= i_wb_dat[5:0]; // [R2] [R9] [R10]
            end
            if (ps_wr && i_wb_sel[0]) begin
                ps_ctrl_q[7:0] <= i_wb_dat[7:0];
            end
            if (ps_wr && i_wb_sel[1]) begin
                ps_ctrl_q[9:8] <= i_wb_dat[9:8];
            end
        end
    end

    // offset calibration storage; read back exactly as written
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ocal_mag_q <= rsc_pkg::RST_OCAL_MAG;
            ocal_sign_q <= 1'b0;
            tc_clear_q <= 1'b0;
        end else begin
            tc_clear_q <= ocal_wr; // [R19]
            if (ocal_wr && i_wb_sel[0]) begin
                ocal_mag_q <= i_wb_dat[7:0]; // [R15] [R18]
            end
            if (ocal_wr && i_wb_sel[1]) begin
                ocal_sign_q <= i_wb_dat[rsc_pkg::OCAL_SIGN_BIT]; // [R15]
            end
        end
    end
    assign o_temp_comp_clear = tc_clear_q;

    // read mux; unmapped addresses answer zero
    always_comb begin
        rdat_d = 32'h0000_0000;
        case (i_wb_adr)
            rsc_pkg::OFS_CTRL: rdat_d = {16'h0000, rsc_pkg::KEY_READBACK, 7'h00, hold_q}; // [R25]
            rsc_pkg::OFS_IRQ_EN: rdat_d = {26'h0, irq_en_q};
            rsc_pkg::OFS_FLAGS: rdat_d = {26'h0, flags_q};
            rsc_pkg::OFS_VECTOR: rdat_d = {28'h0, vec}; // [R7]
            rsc_pkg::OFS_PS_CTRL: rdat_d = {22'h0, ps_ctrl_q};
            rsc_pkg::OFS_OCAL: rdat_d = {16'h0, ocal_sign_q, 7'h00, ocal_mag_q}; // [R18]
            rsc_pkg::OFS_STATUS: rdat_d = {1'b0, slow_q, fast_q, 14'h0, unlocked_q, rs_q};
            default: rdat_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_go;
            if (bus_rd) begin
                rdat_q <= rdat_d;
            end
        end
    end
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // calibration clock pin from the corrected chain
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cal_pin_q <= 1'b0;
        end else begin
            case (calf_sel) // [R21] [R22]
                rsc_pkg::CALF_512: cal_pin_q <= fast_q[5];
                rsc_pkg::CALF_256: cal_pin_q <= fast_q[6];
                default: cal_pin_q <= slow_q[6];
            endcase
        end
    end
    assign o_cal_clock_pin = cal_pin_q;
    assign o_cal_clock_oe = calf_sel != rsc_pkg::CALF_OFF; // [R21]

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    a_rs_keepout: assert property ( // [R1]
        (slow_q == 7'h00 && fast_q < 8'h40) |-> ##2 !rs_q)
        else $error("read-stable high inside keep-out window");
    a_rs_flag_set: assert property ($rose(rs_q) |=> flags_q[1]) // [R2]
        else $error("read-stable rise did not set its flag");
    a_cnt_write_zero: assert property ( // [R5]
        i_count_write |=> fast_q == 8'h00 && slow_q == 7'h00)
        else $error("counting write did not zero prescalers");
    a_irq_vec_tie: assert property ((vec != 4'h0) == o_irq) // [R6]
        else $error("vector and request disagree");
    a_vec_write_clr: assert property (vec_wr |=> flags_q == $past(flag_set)) // [R8]
        else $error("vector write left flags pending");
    a_vec_read_clr: assert property ( // [R3]
        vec_rd && pending != 6'h00 && (flag_set & hi_mask) == 6'h00
        |=> (flags_q & $past(hi_mask)) == 6'h00)
        else $error("vector read did not clear the winner");
    a_hold_stops: assert property ( // [R24]
        hold_q && !i_count_write |=> $stable(fast_q) && $stable(slow_q))
        else $error("prescaler moved while held");
    a_ocal_locked: assert property ( // [R17]
        bus_wr && i_wb_adr == 8'h14 && !unlocked_q |=> $stable(ocal_mag_q))
        else $error("calibration written while locked");
    a_cal_bound: assert property (cal_left_q <= 8'hF0) // [R16]
        else $error("correction count above 240");
    a_tc_clear: assert property (ocal_wr |=> o_temp_comp_clear) // [R19]
        else $error("calibration write did not clear compensation");
    a_key_wrong: assert property ( // [R25]
        ctrl_wr && i_wb_sel[1] && !key_ok |=> !unlocked_q)
        else $error("wrong key left block unlocked");
    a_pin_off: assert property (calf_sel == 2'h0 |-> !o_cal_clock_oe) // [R21]
        else $error("calibration pin driven while off");

    c_rs_rise: cover property ($rose(rs_q));
    c_two_pending_rd: cover property (vec_rd && pending != hi_mask);
    c_cal_up: cover property (cal_fire && advance && ocal_sign_q);
    c_cal_down: cover property (cal_fire && advance && !ocal_sign_q);
endmodule

// *** tb/testbench.sv ***
/* Self-checking bench for rsc_rtc_core: reset values, key lock, vector,
   interval select, read-stable and prescaler flags, cal pin, hold.
   Assumes one-cycle Wishbone ack and a bench-made crystal level. */
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end

module testbench;
    logic i_clock, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_xtal_clk, i_osc_fault;
    logic [7:0] i_wb_adr;
    logic [3:0] i_wb_sel;
    logic [31:0] i_wb_dat, o_wb_dat, rd, rd2;
    logic o_wb_ack, o_temp_comp_clear, o_counter_hold, o_unlocked;
    logic o_irq, o_cal_clock_pin, o_cal_clock_oe, xrun, tcc_seen;
    logic [5:0] ev;
    logic [2:0] xdiv;
    int errors, checks, cycles;

    rsc_rtc_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
        .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
        .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_xtal_clk(i_xtal_clk), .i_osc_fault(i_osc_fault), .i_count_write(ev[5]),
        .i_alarm_match(ev[4]), .i_minute_change(ev[0]), .i_hour_change(ev[1]),
        .i_midnight(ev[2]), .i_noon(ev[3]), .o_second_tick(),
        .o_temp_comp_clear(o_temp_comp_clear), .o_counter_hold(o_counter_hold),
        .o_unlocked(o_unlocked), .o_irq(o_irq), .o_cal_clock_pin(o_cal_clock_pin),
        .o_cal_clock_oe(o_cal_clock_oe));

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // crystal runs at one eighth of the system clock to keep the run short
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (xrun) begin
            xdiv <= xdiv + 3'h1;
            i_xtal_clk <= xdiv[2];
        end
        if (o_temp_comp_clear === 1'b1) tcc_seen <= 1'b1;
        if (cycles == 30000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        @(posedge i_clock);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_sel <= s;
        i_wb_dat <= d;
        do @(posedge i_clock); while (o_wb_ack !== 1'b1);
        rd = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        wb(1'b1, a, s, d);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 4'hF, 32'h0);
        `CHK(rd & m, e)
    endtask

    task automatic pulse(input logic [5:0] m);
        @(posedge i_clock);
        ev <= m;
        @(posedge i_clock);
        ev <= 6'h00;
        repeat (4) @(posedge i_clock);
    endtask

    task automatic t_reset();
        rc(rsc_pkg::OFS_CTRL, 32'h0000FF01, 32'h00009601);
        `CHK(o_counter_hold, 1'b1)
        rc(rsc_pkg::OFS_IRQ_EN, 32'h3F, 32'h0);
        rc(rsc_pkg::OFS_PS_CTRL, 32'h3FF, 32'h0);
        rc(rsc_pkg::OFS_OCAL, 32'h80FF, 32'h0);
        rc(rsc_pkg::OFS_FLAGS, 32'h3F, 32'h0);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h0);
        rc(8'h1C, 32'hFFFFFFFF, 32'h0);
        rc(rsc_pkg::OFS_STATUS, 32'h1, 32'h0);
    endtask

    task automatic t_lock();
        tcc_seen <= 1'b0;
        wr(rsc_pkg::OFS_OCAL, 4'h3, 32'h8005);
        rc(rsc_pkg::OFS_OCAL, 32'h80FF, 32'h0);
        `CHK(tcc_seen, 1'b0)
        wr(rsc_pkg::OFS_CTRL, 4'h2, 32'h0000A500);
        `CHK(o_unlocked, 1'b1)
        wr(rsc_pkg::OFS_OCAL, 4'h3, 32'h80F0);
        rc(rsc_pkg::OFS_OCAL, 32'h80FF, 32'h80F0);
        `CHK(tcc_seen, 1'b1)
        rc(rsc_pkg::OFS_STATUS, 32'h2, 32'h2);
        wr(rsc_pkg::OFS_CTRL, 4'h2, 32'h00001200);
        `CHK(o_unlocked, 1'b0)
        wr(rsc_pkg::OFS_OCAL, 4'h3, 32'h0011);
        rc(rsc_pkg::OFS_OCAL, 32'h80FF, 32'h80F0);
    endtask

    task automatic t_vector();
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h3F);
        i_osc_fault <= 1'b1;
        pulse(6'h11);
        rc(rsc_pkg::OFS_FLAGS, 32'h3F, 32'h0D);
        `CHK(o_irq, 1'b1)
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h08);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h8);
        rc(rsc_pkg::OFS_FLAGS, 32'h3F, 32'h05);
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h3F);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h2);
        `CHK(o_irq, 1'b1)
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h6);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h0);
        `CHK(o_irq, 1'b0)
        pulse(6'h11);
        wr(rsc_pkg::OFS_VECTOR, 4'hF, 32'h0);
        rc(rsc_pkg::OFS_FLAGS, 32'h3F, 32'h0);
        pulse(6'h10);
        wr(rsc_pkg::OFS_FLAGS, 4'h1, 32'h08);
        rc(rsc_pkg::OFS_FLAGS, 32'h3F, 32'h0);
        i_osc_fault <= 1'b0;
    endtask

    task automatic t_interval();
        for (int c = 0; c < 4; c++) begin
            wr(rsc_pkg::OFS_PS_CTRL, 4'h1, 32'(c) << 6);
            pulse({2'b00, 4'hF & ~(4'h1 << c)});
            rc(rsc_pkg::OFS_FLAGS, 32'h4, 32'h0);
            pulse({2'b00, 4'h1 << c});
            rc(rsc_pkg::OFS_FLAGS, 32'h4, 32'h4);
            wr(rsc_pkg::OFS_FLAGS, 4'h1, 32'h04);
        end
        wr(rsc_pkg::OFS_PS_CTRL, 4'h1, 32'h0);
    endtask

    task automatic t_run();
        wr(rsc_pkg::OFS_CTRL, 4'h2, 32'h0000A500);
        wr(rsc_pkg::OFS_OCAL, 4'h3, 32'h0);
        wr(rsc_pkg::OFS_CTRL, 4'h3, 32'h0000A500);
        `CHK(o_counter_hold, 1'b0)
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h0);
        xrun <= 1'b1;
        do wb(1'b0, rsc_pkg::OFS_STATUS, 4'hF, 32'h0); while (rd[0] !== 1'b1);
        rc(rsc_pkg::OFS_FLAGS, 32'h12, 32'h12);
        do wb(1'b0, rsc_pkg::OFS_FLAGS, 4'hF, 32'h0); while (rd[5] !== 1'b1);
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h02);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h4);
        rc(rsc_pkg::OFS_FLAGS, 32'h2, 32'h0);
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h20);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'hC);
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h10);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'hA);
        wr(rsc_pkg::OFS_IRQ_EN, 4'h1, 32'h0);
        rc(rsc_pkg::OFS_VECTOR, 32'hFFFF, 32'h0);
        `CHK(o_irq, 1'b0)
        for (int c = 3; c >= 0; c--) begin
            wr(rsc_pkg::OFS_PS_CTRL, 4'h2, 32'(c) << 8);
            `CHK(o_cal_clock_oe, (c != 0))
        end
        wr(rsc_pkg::OFS_PS_CTRL, 4'h2, 32'h100);
        rd2 = 32'h0;
        rd2[0] = o_cal_clock_pin;
        repeat (700) @(posedge i_clock) if (o_cal_clock_pin !== rd2[0]) rd2[1] = 1'b1;
        `CHK(rd2[1], 1'b1)
        wr(rsc_pkg::OFS_CTRL, 4'h3, 32'h0000A501);
        repeat (20) @(posedge i_clock);
        wb(1'b0, rsc_pkg::OFS_STATUS, 4'hF, 32'h0);
        rd2 = rd;
        repeat (100) @(posedge i_clock);
        rc(rsc_pkg::OFS_STATUS, 32'h7FFF0000, rd2 & 32'h7FFF0000);
        pulse(6'h20);
        rc(rsc_pkg::OFS_STATUS, 32'h7FFF0000, 32'h0);
        xrun <= 1'b0;
    endtask

    initial begin
        i_rst = 1'b1;
        {i_wb_cyc, i_wb_stb, i_wb_we, i_xtal_clk, i_osc_fault, xrun, tcc_seen} = 7'h00;
        i_wb_adr = 8'h00;
        i_wb_sel = 4'h0;
        i_wb_dat = 32'h0;
        ev = 6'h00;
        xdiv = 3'h0;
        errors = 0;
        checks = 0;
        cycles = 0;
        repeat (4) @(posedge i_clock);
        i_rst <= 1'b0;
        t_reset();
        t_lock();
        t_vector();
        t_interval();
        t_run();
        wrap_up();
    end
endmodule
